// >>> common/sc_seq_pkg.sv
// Shared constants and carrier types for the smart card power sequencer
package sc_seq_pkg;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 4;
    localparam int RELEASE_DELAY_US = 800;
    localparam int RELEASE_CYC = (RELEASE_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int SHUT_DELAY_US = 8;
    localparam int SHUT_CYC = (SHUT_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int SHUT_CLK_EDGES = 2;
    localparam int SEL_A = 0;
    localparam int SEL_B = 1;

    // ==========================================================
    // Carrier types
    // ==========================================================
    typedef struct packed {
        logic enable;
        logic contact_set_select;
        logic supply_level_select;
        logic host_ok;
        logic host_reset;
        logic host_clock;
        logic host_data;
    } host_side_t;

    typedef struct packed {
        logic supply_on;
        logic supply_3v0;
        logic reset;
        logic clock;
        logic data_oe;
        logic data_out;
    } card_drive_t;
endpackage

// >>> src/sc_sync2.sv
// Two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module sc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,              // Core clock
    input wire logic rst_n_i,            // Async reset, active low
    input wire logic [WIDTH-1:0] d_i,    // Asynchronous levels
    output logic [WIDTH-1:0] q_o         // Synchronised levels
);
    logic [WIDTH-1:0] meta_q;

    // Two-stage capture; first stage read only by second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

// >>> src/sc_power_seq.sv
// Activation and deactivation sequencer for two smart card contact sets
`timescale 1ns/1ps
`default_nettype none
module sc_power_seq #(
    parameter int RELEASE_CYCLES = sc_seq_pkg::RELEASE_CYC,
    parameter int SHUT_CYCLES = sc_seq_pkg::SHUT_CYC
) (
    input wire logic clk_i,                      // 250 MHz core clock
    input wire logic rst_n_i,                    // Async reset, active low
    input wire sc_seq_pkg::host_side_t host_i,   // Asynchronous host pins
    input wire logic supply_good_i,              // Selected supply at nominal
    input wire logic [1:0] card_data_line_i,     // Card data pin levels, A/B
    output logic host_data_oe_o,                 // Drive host data low
    output logic host_data_o,                    // Host data output value
    output logic [1:0] card_supply_out_o,        // Card supply switch, A/B
    output logic card_supply_3v0_o,              // Supply level, 1 = 3.0 V
    output logic [1:0] card_reset_out_o,         // Card reset, A/B
    output logic [1:0] card_clock_out_o,         // Card clock, A/B
    output logic [1:0] card_data_line_oe_o,      // Card data drive enable, A/B
    output logic [1:0] card_data_line_o,         // Card data output value
    output logic active_o                        // Session running
);
    // ==========================================================
    // Input synchronisation
    // ==========================================================
    sc_seq_pkg::host_side_t hs;
    logic sup_good;
    logic [1:0] cdl;
    logic [9:0] sync_q;

    sc_sync2 #(.WIDTH(10)) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i({host_i, supply_good_i, card_data_line_i}),
        .q_o(sync_q)
    );

    // Unpack synchronised bundle
    assign hs = sc_seq_pkg::host_side_t'(sync_q[9:3]);
    assign sup_good = sync_q[2];
    assign cdl = sync_q[1:0];

    // ==========================================================
    // Sequencer state
    // ==========================================================
    typedef enum logic [2:0] {
        ST_OFF, ST_RAMP, ST_WAIT, ST_RUN, ST_SHUT, ST_PWROFF
    } seq_state_t;

    seq_state_t state_q, state_d;
    logic [19:0] cnt_q;
    logic set_q;
    logic lvl_q;
    logic hclk_q;
    logic hclk_rise;
    logic [1:0] rise_cnt_q;
    logic clk_en_q;
    logic clk_low_q;
    logic [1:0] shut_edge_q;
    logic stop_req;
    logic [1:0] dir_q;
    logic [1:0] hold_q;

    // Host clock edge detection on synchronised copy
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hclk_q <= 1'b0;
        end else begin
            hclk_q <= hs.host_clock;
        end
    end
    assign hclk_rise = hs.host_clock & ~hclk_q;

    // Enable low or host supply loss both end the session
    assign stop_req = !hs.enable || !hs.host_ok;

    // Next-state logic
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_OFF: if (!stop_req) state_d = ST_RAMP;
            ST_RAMP: begin
                if (stop_req) state_d = ST_SHUT;
                else if (sup_good) state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (stop_req) state_d = ST_SHUT;
                else if (cnt_q == 20'(RELEASE_CYCLES - 1)) state_d = ST_RUN;
            end
            ST_RUN: if (stop_req) state_d = ST_SHUT;
            ST_SHUT: if (cnt_q == 20'(SHUT_CYCLES - 1)) state_d = ST_PWROFF;
            ST_PWROFF: state_d = ST_OFF;
        endcase
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // Delay counter, cleared on each state change
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else if (state_d != state_q) begin
            cnt_q <= '0;
        end else if (state_q == ST_WAIT || state_q == ST_SHUT) begin
            cnt_q <= cnt_q + 20'd1;
        end
    end

    // Contact set and level latched at activation so only one set runs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            set_q <= 1'b0;
            lvl_q <= 1'b0;
        end else if (state_q == ST_OFF && !stop_req) begin
            set_q <= hs.contact_set_select;
            lvl_q <= hs.supply_level_select;
        end
    end

    // Clock gate opens on second host clock rise after release
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rise_cnt_q <= 2'd0;
            clk_en_q <= 1'b0;
        end else if (state_q != ST_RUN && state_q != ST_SHUT) begin
            rise_cnt_q <= 2'd0;
            clk_en_q <= 1'b0;
        end else if (state_q == ST_RUN && !clk_en_q && hclk_rise) begin
            rise_cnt_q <= rise_cnt_q + 2'd1;
            if (rise_cnt_q == 2'd1) clk_en_q <= 1'b1;
        end
    end

    // Shutdown: clock low after two host clock edges, or at 8 us
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shut_edge_q <= 2'd0;
            clk_low_q <= 1'b0;
        end else if (state_q != ST_SHUT) begin
            shut_edge_q <= 2'd0;
            clk_low_q <= 1'b0;
        end else begin
            if (hclk_rise && shut_edge_q != 2'(sc_seq_pkg::SHUT_CLK_EDGES)) begin
                shut_edge_q <= shut_edge_q + 2'd1;
            end
            if (shut_edge_q == 2'(sc_seq_pkg::SHUT_CLK_EDGES) && !hs.host_clock) begin
                clk_low_q <= 1'b1;
            end
            if (cnt_q == 20'(SHUT_CYCLES - 1)) clk_low_q <= 1'b1;
        end
    end

    // Data direction owner, blanked while the pin echo settles
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_q <= 2'b00;
            hold_q <= 2'd3;
        end else if (state_q != ST_RUN) begin
            dir_q <= 2'b00;
            hold_q <= 2'd3;
        end else if (hold_q != 2'd0) begin
            hold_q <= hold_q - 2'd1;
        end else if (dir_q == 2'b00) begin
            dir_q <= {!cdl[set_q] && hs.host_data, !hs.host_data};
        end else if (dir_q[0] ? hs.host_data : cdl[set_q]) begin
            dir_q <= 2'b00;
            hold_q <= 2'd3;
        end
    end

    // ==========================================================
    // Output drive
    // ==========================================================
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            card_supply_out_o <= 2'b00;
            card_supply_3v0_o <= 1'b0;
            card_reset_out_o <= 2'b00;
            card_clock_out_o <= 2'b00;
            card_data_line_oe_o <= 2'b00;
            card_data_line_o <= 2'b00;
            host_data_oe_o <= 1'b0;
            host_data_o <= 1'b0;
            active_o <= 1'b0;
        end else begin
            card_supply_out_o <= 2'b00;
            card_reset_out_o <= 2'b00;
            card_clock_out_o <= 2'b00;
            card_data_line_oe_o <= 2'b00;
            card_data_line_o <= 2'b00;
            host_data_oe_o <= 1'b0;
            host_data_o <= 1'b0;
            active_o <= (state_q == ST_RUN);
            card_supply_3v0_o <= lvl_q;
            unique case (state_q)
                ST_RAMP, ST_WAIT: begin
                    card_supply_out_o[set_q] <= 1'b1;
                    card_data_line_oe_o[set_q] <= 1'b1;
                end
                ST_RUN: begin
                    card_supply_out_o[set_q] <= 1'b1;
                    card_reset_out_o[set_q] <= hs.host_reset;
                    card_clock_out_o[set_q] <= clk_en_q & hs.host_clock;
                    card_data_line_oe_o[set_q] <= dir_q[0];
                    host_data_oe_o <= dir_q[1];
                end
                ST_SHUT: begin
                    card_supply_out_o[set_q] <= 1'b1;
                    card_clock_out_o[set_q] <= !clk_low_q && clk_en_q && hs.host_clock;
                    card_data_line_oe_o[set_q] <= (cnt_q == 20'(SHUT_CYCLES - 1));
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    chk_reset_while_ramp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_RAMP) |=> (card_reset_out_o == 2'b00 && card_clock_out_o == 2'b00))
        else $error("card lines not low during ramp");
    chk_single_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        card_supply_out_o != 2'b11)
        else $error("both contact sets powered");
    chk_reset_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_SHUT) |=> (card_reset_out_o == 2'b00))
        else $error("reset not forced low in shutdown");
    chk_release_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_RUN && $past(state_q) == ST_WAIT) |-> $past(cnt_q) == 20'(RELEASE_CYCLES - 1))
        else $error("release delay wrong");
    chk_stop_enters_shut: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (stop_req && (state_q == ST_RUN || state_q == ST_WAIT)) |=> state_q == ST_SHUT)
        else $error("stop did not start shutdown");
    chk_clk_low_8us: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_PWROFF) |-> card_clock_out_o == 2'b00)
        else $error("clock not low at shutdown end");
    chk_supply_last: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(|card_supply_out_o) |-> (card_reset_out_o == 2'b00 && card_clock_out_o == 2'b00
            && $past(|card_data_line_oe_o)))
        else $error("supply dropped before lines low");
    chk_clk_gate_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_RUN && !clk_en_q) |=> card_clock_out_o == 2'b00)
        else $error("card clock before second edge");
endmodule
`default_nettype wire

// >>> verification/sc_far_model.sv
// Host clock source and card data line model for the sequencer bench
`timescale 1ns/1ps
`default_nettype none
module sc_far_model (
    input wire logic run_i,             // Frame active, host clock runs
    input wire logic [1:0] card_oe_i,   // Design pulls card data low
    input wire logic [1:0] card_low_i,  // Card pulls its data low
    output logic host_clk_o,            // Host clock, 80 ns period
    output logic [1:0] card_level_o     // Resolved card data lines
);
    // ==========================================================
    // Host clock
    // ==========================================================
    // Toggles only within frames, idles low between them
    initial host_clk_o = 1'b0;
    always begin
        #40;
        host_clk_o = run_i ? ~host_clk_o : 1'b0;
    end

    // Open-drain card data with pull-up, low if either side drives
    assign card_level_o = ~(card_oe_i | card_low_i);
endmodule
`default_nettype wire

// >>> verification/sc_power_seq_tb.sv
// Self-checking bench for the smart card power sequencer
`timescale 1ns/1ps
`default_nettype none
module sc_power_seq_tb;
    localparam int REL = 50;
    localparam int SHUT = 200;
    typedef struct {logic cs; logic lv; logic via_ok;} row_t;
    logic clk_i = 1'b0, rst_n_i = 1'b0, en = 1'b0, cs = 1'b0, lv = 1'b0, ok = 1'b1;
    logic hrst = 1'b1, hdat = 1'b1, good = 1'b0, run = 1'b0, hclk, hd_oe, hd_o, v3, on;
    logic [1:0] low = 2'b00, lvl, sup, crst, cclk, coe, cdo;
    sc_seq_pkg::host_side_t host;
    int mismatches = 0, checks_done = 0, cyc = 0, n, t0;
    row_t rows [4] = '{'{0, 0, 0}, '{0, 1, 0}, '{1, 0, 0}, '{1, 1, 1}};

    // ==========================================================
    // Clock, host pins and instances
    // ==========================================================
    always #2 clk_i = ~clk_i;
    assign host = {en, cs, lv, ok, hrst, hclk, hdat & ~hd_oe};
    sc_far_model u_far (.run_i(run), .card_oe_i(coe), .card_low_i(low),
        .host_clk_o(hclk), .card_level_o(lvl));
    sc_power_seq #(.RELEASE_CYCLES(REL), .SHUT_CYCLES(SHUT)) u_dut (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .host_i(host), .supply_good_i(good), .card_data_line_i(lvl),
        .host_data_oe_o(hd_oe), .host_data_o(hd_o), .card_supply_out_o(sup),
        .card_supply_3v0_o(v3), .card_reset_out_o(crst), .card_clock_out_o(cclk),
        .card_data_line_oe_o(coe), .card_data_line_o(cdo), .active_o(on));

    // Cut a hung run short
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input logic c, input string msg);
        checks_done++;
        if (c !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    task automatic act(input row_t r);
        en = 1'b1;
        cs = r.cs;
        lv = r.lv;
        for (n = 0; n < 10 && sup === 2'b00; n++) step(1);
        chk(sup === {r.cs, ~r.cs} && v3 === r.lv, "set or level");
        step(20);
        chk(crst === 2'b00 && cclk === 2'b00 && coe[r.cs] === 1'b1, "lines low");
        good = 1'b1;
        for (n = 0; n < REL + 20 && on !== 1'b1; n++) step(1);
        chk(n >= REL && n <= REL + 8, "release delay");
        chk(crst[r.cs] === 1'b1 && coe === 2'b00, "reset released");
        run = 1'b1;
        cs = ~r.cs;
        hrst = 1'b0;
        step(15);
        chk(cclk === 2'b00 && crst === 2'b00, "early clock");
        for (n = 0; n < 60 && cclk[r.cs] !== 1'b1; n++) step(1);
        chk(cclk[r.cs] === 1'b1 && cclk[~r.cs] === 1'b0, "clock set");
        chk(sup === {r.cs, ~r.cs}, "select change taken");
        hdat = 1'b0;
        step(6);
        chk(coe[r.cs] === 1'b1, "host to card");
        hdat = 1'b1;
        low[r.cs] = 1'b1;
        step(12);
        chk(hd_oe === 1'b1, "card to host");
        low = 2'b00;
        hrst = 1'b1;
        step(6);
        chk(coe === 2'b00 && hd_oe === 1'b0, "data not released");
        chk(cdo === 2'b00 && hd_o === 1'b0, "open drain value");
    endtask

    task automatic deact(input logic via_ok);
        t0 = cyc;
        if (via_ok) ok = 1'b0;
        else en = 1'b0;
        for (n = 0; n < 8 && crst !== 2'b00; n++) step(1);
        chk(crst === 2'b00 && coe === 2'b00, "reset not first");
        for (n = 0; n < 50 && cclk !== 2'b00; n++) step(1);
        chk(cclk === 2'b00 && coe === 2'b00, "clock stop");
        for (n = 0; n < SHUT && coe === 2'b00; n++) step(1);
        chk(cyc - t0 >= SHUT && cyc - t0 <= SHUT + 8, "data low time");
        chk(sup !== 2'b00, "supply off early");
        step(4);
        chk(sup === 2'b00 && on === 1'b0 && crst === 2'b00, "supply on");
        run = 1'b0;
        good = 1'b0;
        ok = 1'b1;
        en = 1'b0;
        step(4);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        step(2);
        rst_n_i = 1'b1;
        chk(sup === 2'b00 && coe === 2'b00 && on === 1'b0, "reset values");
        foreach (rows[i]) begin
            act(rows[i]);
            deact(rows[i].via_ok);
        end
        // Host supply low blocks activation
        ok = 1'b0;
        en = 1'b1;
        step(10);
        chk(sup === 2'b00, "started without host supply");
        ok = 1'b1;
        en = 1'b0;
        // Abort while the supply ramps
        step(2);
        en = 1'b1;
        step(6);
        en = 1'b0;
        for (n = 0; n < SHUT + 20 && sup !== 2'b00; n++) step(1);
        chk(sup === 2'b00 && crst === 2'b00, "abort in ramp");
        // Reset in mid-session
        act(rows[2]);
        rst_n_i = 1'b0;
        #1;
        chk(sup === 2'b00 && cclk === 2'b00 && crst === 2'b00 && on === 1'b0, "async reset");
        run = 1'b0;
        good = 1'b0;
        en = 1'b0;
        step(2);
        rst_n_i = 1'b1;
        step(4);
        wrap_up();
    end
endmodule
`default_nettype wire
